/* common/acc_pkg.sv */
// package for the comparator control block: register map, field layout,
// reset values, edge modes and start-up timing.
// assumes a 10 MHz peripheral clock and 32-bit apb data.
package acc_pkg;

	// clock period, for deriving cycle counts from times
	localparam int CLK_PERIOD_NS = 100;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_CONTROL   = 8'h00;
	localparam logic [7:0] IDX_MUX       = 8'h02;
	localparam logic [7:0] IDX_INT_EN    = 8'h06;
	localparam logic [7:0] IDX_STATUS    = 8'h07;
	localparam logic [7:0] ADDR_CONTROL  = 8'(IDX_CONTROL * 4);
	localparam logic [7:0] ADDR_MUX      = 8'(IDX_MUX * 4);
	localparam logic [7:0] ADDR_INT_EN   = 8'(IDX_INT_EN * 4);
	localparam logic [7:0] ADDR_STATUS   = 8'(IDX_STATUS * 4);

	// reset values
	localparam logic [7:0] RST_CONTROL   = 8'h00;
	localparam logic [7:0] RST_MUX       = 8'h00;
	localparam logic [7:0] RST_INT_EN    = 8'h00;

	// control register fields
	localparam int CTL_ENABLE    = 0;
	localparam int CTL_HYS_LO    = 1;
	localparam int CTL_LOW_POWER = 3;
	localparam int CTL_EDGE_LO   = 4;
	localparam int CTL_PAD_EN    = 6;
	localparam int CTL_RUN_STBY  = 7;

	// mux control register fields
	localparam int MUX_NEG_LO    = 0;
	localparam int MUX_POS_LO    = 3;
	localparam int MUX_INVERT    = 7;
	localparam logic [7:0] MUX_WRITE_MASK = 8'h9B;

	// interrupt enable and status fields
	localparam int INTEN_CMP     = 0;
	localparam int STAT_FLAG     = 0;
	localparam int STAT_STATE    = 4;

	// single interrupt vector of this block
	localparam logic [7:0] VECTOR_OFFSET = 8'h00;

	// interrupt edge modes
	typedef enum logic [1:0] {
		EDGE_ANY      = 2'b00,
		EDGE_RESERVED = 2'b01,
		EDGE_FALLING  = 2'b10,
		EDGE_RISING   = 2'b11
	} acc_edge_t;

	// negative input codes, then the positive pin zero code
	localparam logic [1:0] NEG_PIN_ZERO  = 2'h0;
	localparam logic [1:0] NEG_VREF      = 2'h2;
	localparam logic [1:0] NEG_DAC       = 2'h3;
	localparam logic [1:0] POS_PIN_ZERO  = 2'h0;

	// start-up hold-off times and their cycle counts (rounded up)
	localparam int STARTUP_CORE_NS = 2500;
	localparam int STARTUP_VREF_NS = 60000;
	localparam int STARTUP_CORE_CYC =
		(STARTUP_CORE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STARTUP_VREF_CYC =
		(STARTUP_VREF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// settings handed to the analog core
	typedef struct packed {
		logic       enable;
		logic       low_power;
		logic [1:0] hysteresis;
		logic [1:0] positive_sel;
		logic [1:0] negative_sel;
	} acc_core_cfg_t;

endpackage

/* hdl/acc_sync.sv */
// multi-stage synchroniser for one level from outside the clock domain.
// assumes the input may change at any time; only the last stage is read.
`timescale 1ns/1ns
module acc_sync
	import acc_pkg::*;
#(
	parameter int STAGES = 3
)
(
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic din,
	output logic      dout
);

	logic [STAGES-1:0] chain_reg;

	// shift chain; each stage feeds only the next one
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			chain_reg <= '0;
		else
			chain_reg <= {chain_reg[STAGES-2:0], din};
	end

	assign dout = chain_reg[STAGES-1];

endmodule

/* hdl/acc_startup.sv */
// start-up hold-off counter: flags the comparator result valid once the
// chosen settling time has passed since the core was switched on.
// assumes run is a level from logic on the same clock.
`timescale 1ns/1ns
module acc_startup
	import acc_pkg::*;
#(
	parameter int CW = 10
)
(
	input  wire logic          pclk,
	input  wire logic          presetn,
	input  wire logic          run,
	input  wire logic [CW-1:0] wait_cycles,
	output logic               valid
);

	logic [CW-1:0] count_reg;

	// count up while running; restart whenever the core is off
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			count_reg <= '0;
		else if (!run)
			count_reg <= '0;
		else if (count_reg < wait_cycles)
			count_reg <= count_reg + 1'b1;
	end

	// valid level, registered
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			valid <= 1'b0;
		else
			valid <= run && (count_reg >= wait_cycles);
	end

endmodule

/* hdl/acc_top.sv */
// comparator control logic: apb register file, core configuration,
// inversion, pad and event drive, state synchroniser, edge interrupt and
// sleep gating around one analog comparator.
// assumes the analog core, reference, dac, pin muxing and interrupt
// controller sit outside; sleep inputs come from logic on pclk.
`timescale 1ns/1ns
module acc_top
	import acc_pkg::*;
#(
	parameter int SYNC_STAGES = 3,
	parameter int STARTUP_CW  = 10
)
(
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [7:0]  paddr,
	input  wire logic [31:0] pwdata,
	output logic [31:0]      prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        cmp_raw,
	input  wire logic        sleep_idle,
	input  wire logic        sleep_standby,
	input  wire logic        sleep_powerdown,
	output acc_core_cfg_t    core_cfg,
	output logic             pad_out,
	output logic             pad_drive,
	output logic             event_out,
	output logic             result_valid,
	output logic             irq
);

	// software registers
	logic [7:0]    control_reg;
	logic [7:0]    mux_reg;
	logic [7:0]    int_en_reg;
	logic          flag_reg;
	logic          state_prev_reg;

	// decoded fields
	logic          enable_bit;
	logic [1:0]    hys_field;
	logic          low_power_bit;
	acc_edge_t     edge_mode;
	logic          pad_en_bit;
	logic          run_stby_bit;
	logic          invert_bit;
	logic [1:0]    pos_field;
	logic [1:0]    neg_field;

	// internal signals
	logic          core_run;
	logic          clock_halted;
	logic          result_async;
	logic          raw_synced;
	logic          state_now;
	logic          rise_seen;
	logic          fall_seen;
	logic          edge_hit;
	logic          setup_phase;
	logic          access_done;
	logic          wr_access;
	logic          addr_hit;
	logic          flag_clear;
	logic [31:0]   read_mux;
	logic [STARTUP_CW-1:0] hold_off;

	// field decode from the stored registers
	assign enable_bit    = control_reg[CTL_ENABLE];
	assign hys_field     = control_reg[CTL_HYS_LO +: 2];
	assign low_power_bit = control_reg[CTL_LOW_POWER];
	assign edge_mode     = acc_edge_t'(control_reg[CTL_EDGE_LO +: 2]);
	assign pad_en_bit    = control_reg[CTL_PAD_EN];
	assign run_stby_bit  = control_reg[CTL_RUN_STBY];
	assign invert_bit    = mux_reg[MUX_INVERT];
	assign pos_field     = mux_reg[MUX_POS_LO +: 2];
	assign neg_field     = mux_reg[MUX_NEG_LO +: 2];

	// sleep gating; idle is deliberately not a term here
	// enable gates the core
	assign core_run = enable_bit && !sleep_powerdown
		&& !(sleep_standby && !run_stby_bit);

	// in standby the peripheral clock is treated as stopped for status
	// status and flag freeze
	assign clock_halted = sleep_standby || sleep_powerdown;

	// no debug input exists, so a halted cpu freezes nothing here

	// apb phase decode
	assign setup_phase = psel && !penable;
	assign access_done = psel && penable && pready;
	assign wr_access   = access_done && pwrite;

	// address decode: word aligned, four mapped words
	always_comb
	begin
		addr_hit = 1'b0;
		if (paddr[1:0] == 2'b00)
		begin
			case (paddr)
				ADDR_CONTROL: addr_hit = 1'b1;
				ADDR_MUX:     addr_hit = 1'b1;
				ADDR_INT_EN:  addr_hit = 1'b1;
				ADDR_STATUS:  addr_hit = 1'b1;
				default:      addr_hit = 1'b0;
			endcase
		end
	end

	// read data selection; unused upper bits read as zero
	always_comb
	begin
		read_mux = 32'h0000_0000;
		case (paddr)
			ADDR_CONTROL: read_mux[7:0] = control_reg;
			ADDR_MUX:     read_mux[7:0] = mux_reg;
			ADDR_INT_EN:  read_mux[7:0] = int_en_reg;
			ADDR_STATUS:
			begin
				read_mux[STAT_FLAG]  = flag_reg;
				// state shows its last sample while the clock is stopped
				// state frozen in standby
				read_mux[STAT_STATE] = clock_halted ? state_prev_reg
					: state_now;
			end
			default:      read_mux = 32'h0000_0000;
		endcase
	end

	// no wait state: ready rises in the first access cycle
	// registering ready from the setup phase costs no cycle and keeps decode off the output
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			pready <= 1'b0;
		else
			pready <= setup_phase;
	end

	// read data and error captured at the setup edge, stable in access
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
		else if (setup_phase)
		begin
			prdata  <= pwrite ? 32'h0000_0000 : read_mux;
			pslverr <= !addr_hit;
		end
		else if (access_done)
		begin
			prdata  <= 32'h0000_0000;
			pslverr <= 1'b0;
		end
	end

	// control register; software is expected to write enable last
	// enable set by software last
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			control_reg <= RST_CONTROL;
		else if (wr_access && paddr == ADDR_CONTROL)
			control_reg <= pwdata[7:0];
	end

	// mux control; reserved bits are not stored and read zero
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			mux_reg <= RST_MUX;
		else if (wr_access && paddr == ADDR_MUX)
			mux_reg <= pwdata[7:0] & MUX_WRITE_MASK;
	end

	// interrupt enable; only the compare bit exists
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			int_en_reg <= RST_INT_EN;
		else if (wr_access && paddr == ADDR_INT_EN)
			int_en_reg <= {7'h00, pwdata[INTEN_CMP]};
	end

	// configuration to the analog core, registered
	// hysteresis level to core
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			core_cfg <= '0;
		else
		begin
			core_cfg.enable       <= core_run;
			core_cfg.low_power    <= low_power_bit;
			core_cfg.hysteresis   <= hys_field;
			core_cfg.positive_sel <= pos_field;
			core_cfg.negative_sel <= neg_field;
		end
	end

	// result path without any clock, so pad and event still follow the
	// core while the peripheral clock is stopped in standby
	// raw is one for positive above negative
	assign result_async = cmp_raw ^ invert_bit;

	assign event_out = core_run && result_async;

	assign pad_out   = core_run && pad_en_bit && result_async;
	assign pad_drive = core_run && pad_en_bit;

	// synchroniser for the state bit; raw input is asynchronous
	// three-stage state synchroniser
	acc_sync #(
		.STAGES (SYNC_STAGES)
	) u_sync (
		.pclk    (pclk),
		.presetn (presetn),
		.din     (cmp_raw),
		.dout    (raw_synced)
	);

	assign state_now = core_run && (raw_synced ^ invert_bit);

	// previous sample for edge detection; held while clock is halted
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			state_prev_reg <= 1'b0;
		else if (!clock_halted)
			state_prev_reg <= state_now;
	end

	assign rise_seen = state_now && !state_prev_reg;
	assign fall_seen = !state_now && state_prev_reg;

	// edge qualification by the selected mode
	// the reserved code never flags, so a stray write stays quiet
	// edge mode selection
	always_comb
	begin
		edge_hit = 1'b0;
		case (edge_mode)
			EDGE_ANY:      edge_hit = rise_seen || fall_seen;
			EDGE_FALLING:  edge_hit = fall_seen;
			EDGE_RISING:   edge_hit = rise_seen;
			EDGE_RESERVED: edge_hit = 1'b0;
			default:       edge_hit = 1'b0;
		endcase
	end

	assign flag_clear = wr_access && (paddr == ADDR_STATUS)
		&& pwdata[STAT_FLAG];

	// interrupt flag; a new edge wins over a clear in the same cycle,
	// and a halted clock neither sets nor clears it
	// a clear written during standby is lost, as status cannot update
	// edge sets the flag
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			flag_reg <= 1'b0;
		else if (clock_halted)
			flag_reg <= flag_reg;
		else if (core_run && edge_hit)
			flag_reg <= 1'b1;
		else if (flag_clear)
			flag_reg <= 1'b0;
	end

	// request on the single vector at VECTOR_OFFSET
	// flag and enable hold request
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			irq <= 1'b0;
		else
			irq <= flag_reg && int_en_reg[INTEN_CMP];
	end

	// settling time grows when the reference must start as well
	// both counts must fit the counter; a longer reference time needs
	// a wider STARTUP_CW
	// start-up hold-off length
	assign hold_off = (neg_field == NEG_VREF)
		? STARTUP_CW'(STARTUP_VREF_CYC)
		: STARTUP_CW'(STARTUP_CORE_CYC);

	// result valid indication after start-up
	// valid after hold-off
	acc_startup #(
		.CW (STARTUP_CW)
	) u_startup (
		.pclk        (pclk),
		.presetn     (presetn),
		.run         (core_run),
		.wait_cycles (hold_off),
		.valid       (result_valid)
	);

endmodule

/* verification/acc_top_sva.sv */
// port checks for the comparator control block.
// assumes it is bound into acc_top; one clock, reset active low.
`timescale 1ns/1ns
module acc_top_sva
	import acc_pkg::*;
(
	input logic          pclk,
	input logic          presetn,
	input logic          psel,
	input logic          penable,
	input logic          pwrite,
	input logic [7:0]    paddr,
	input logic [31:0]   pwdata,
	input logic          pready,
	input logic          sleep_powerdown,
	input acc_core_cfg_t core_cfg,
	input logic          pad_out,
	input logic          pad_drive,
	input logic          event_out,
	input logic          result_valid,
	input logic          irq
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);

	// completed write to one register; settings land two edges on
	sequence s_ctl_wr;
		psel && penable && pready && pwrite && paddr == ADDR_CONTROL;
	endsequence
	sequence s_mux_wr;
		psel && penable && pready && pwrite && paddr == ADDR_MUX;
	endsequence
	sequence s_ien_wr;
		psel && penable && pready && pwrite && paddr == ADDR_INT_EN;
	endsequence

	property p_pad_follow;
		pad_drive |-> pad_out == event_out;
	endproperty
	a_pad_follow: assert property (p_pad_follow)
		else $error("pad output differs from comparator result");
	property p_pad_idle;
		!pad_drive |-> !pad_out;
	endproperty
	a_pad_idle: assert property (p_pad_idle)
		else $error("pad output high while not driven");
	property p_pdown;
		sleep_powerdown |-> !pad_drive && !event_out;
	endproperty
	a_pdown: assert property (p_pdown)
		else $error("comparator active in power-down");
	property p_disable;
		s_ctl_wr ##0 !pwdata[CTL_ENABLE] |=> !event_out && !pad_drive;
	endproperty
	a_disable: assert property (p_disable)
		else $error("comparator still active after disable");
	property p_ctl_cfg;
		s_ctl_wr |-> ##2 core_cfg.low_power == $past(pwdata[3], 2)
			&& core_cfg.hysteresis == $past(pwdata[2:1], 2);
	endproperty
	a_ctl_cfg: assert property (p_ctl_cfg)
		else $error("core hysteresis or low power wrong");
	property p_mux_cfg;
		s_mux_wr |-> ##2 core_cfg.negative_sel == $past(pwdata[1:0], 2)
			&& core_cfg.positive_sel == $past(pwdata[4:3], 2);
	endproperty
	a_mux_cfg: assert property (p_mux_cfg)
		else $error("core input selection wrong");
	property p_irq_mask;
		s_ien_wr ##0 !pwdata[INTEN_CMP] |-> ##2 !irq [*2];
	endproperty
	a_irq_mask: assert property (p_irq_mask)
		else $error("interrupt request while disabled");
	property p_valid_drop;
		sleep_powerdown |=> !result_valid;
	endproperty
	a_valid_drop: assert property (p_valid_drop)
		else $error("result valid kept in power-down");
endmodule

bind acc_top acc_top_sva u_sva (.pclk(pclk), .presetn(presetn),
	.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
	.pwdata(pwdata), .pready(pready), .sleep_powerdown(sleep_powerdown),
	.core_cfg(core_cfg), .pad_out(pad_out), .pad_drive(pad_drive),
	.event_out(event_out), .result_valid(result_valid), .irq(irq));

/* verification/acc_core_model.sv */
// behavioural analog comparator core driven by the block's settings.
// assumes input levels in millivolts come from the bench.
`timescale 1ns/1ns
module acc_core_model
	import acc_pkg::*;
#(
	parameter int REF_MV = 120
)
(
	input  acc_core_cfg_t cfg,
	input  int            pos_mv,
	input  int            neg_mv,
	output logic          cmp_raw
);
	int neg_sel;

	// internal sources share one level; only pin zero is external
	assign neg_sel = (cfg.negative_sel == NEG_PIN_ZERO) ? neg_mv : REF_MV;

	// an idle core gives no valid answer, so it flips its last value
	initial
		cmp_raw = 1'b0;
	always @(cfg.enable, pos_mv, neg_sel)
	begin
		if (cfg.enable)
			cmp_raw = pos_mv > neg_sel; // positive above negative
		else
			cmp_raw = ~cmp_raw;
	end
endmodule

/* verification/tb.sv */
// self-checking bench for the comparator control block over apb.
// assumes the core model on the far side and default parameters.
`timescale 1ns/1ns
module tb;
	import acc_pkg::*;
	logic          pclk, presetn, psel, penable, pwrite, err, f;
	logic [7:0]    paddr;
	logic [31:0]   pwdata, prdata, rdat;
	logic          pready, pslverr, cmp_raw, pad_out, pad_drive;
	logic          sleep_idle, sleep_standby, sleep_powerdown;
	logic          event_out, result_valid, irq;
	acc_core_cfg_t core_cfg;
	acc_edge_t     m;
	acc_edge_t     modes[4] = '{EDGE_ANY, EDGE_FALLING, EDGE_RISING,
		EDGE_RESERVED};
	int            pos_mv, neg_mv, n_fail, samples_checked;

	acc_top uut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .cmp_raw(cmp_raw), .sleep_idle(sleep_idle),
		.sleep_standby(sleep_standby), .sleep_powerdown(sleep_powerdown),
		.core_cfg(core_cfg), .pad_out(pad_out), .pad_drive(pad_drive),
		.event_out(event_out), .result_valid(result_valid), .irq(irq));
	acc_core_model core_model (.cfg(core_cfg), .pos_mv(pos_mv),
		.neg_mv(neg_mv), .cmp_raw(cmp_raw));

	// one apb transfer; the request stands until pready is seen
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1)
			@(posedge pclk);
		rdat = prdata;
		err  = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		xfer(1'b1, a, d);
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
		xfer(1'b0, a, 32'h0000_0000);
		chk(rdat, exp);
	endtask
	task automatic cyc(input int n);
		repeat (n)
			@(posedge pclk);
	endtask
	task automatic results();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// free-running peripheral clock
	initial
	begin
		pclk = 1'b0;
		forever
			#50 pclk = ~pclk;
	end

	// watchdog: the tests need under two thousand cycles
	initial
	begin
		cyc(5000);
		n_fail++;
		results();
	end

	// main sequence
	initial
	begin
		{presetn, psel, penable, pwrite} = 4'h0;
		{sleep_idle, sleep_standby, sleep_powerdown} = 3'h0;
		paddr  = 8'h00;
		pwdata = 32'h0000_0000;
		pos_mv = 50;
		neg_mv = 100;
		n_fail = 0;
		samples_checked = 0;
		cyc(6);
		presetn <= 1'b1;
		rd_chk(ADDR_CONTROL, 32'h0000_0000); // control reset
		rd_chk(ADDR_MUX, 32'h0000_0000); // mux reset
		rd_chk(ADDR_INT_EN, 32'h0000_0000); // enable reset
		rd_chk(ADDR_STATUS, 32'h0000_0000); // status reset
		rd_chk(8'h04, 32'h0000_0000);
		chk(err, 1'b1);
		wr(ADDR_MUX, 32'h0000_00FF);
		rd_chk(ADDR_MUX, {24'h0, MUX_WRITE_MASK}); // fields
		$display("test registers done");
		// inputs first, pad next, enable last
		wr(ADDR_MUX, 32'h0000_0000);
		wr(ADDR_CONTROL, 32'h0000_004E);
		cyc(2);
		chk(pad_drive, 1'b0); // pad off while disabled
		chk(core_cfg, 8'h70); // hysteresis and low power
		wr(ADDR_CONTROL, 32'h0000_004F); // enable written last
		pos_mv <= 200;
		cyc(2);
		chk({pad_drive, pad_out, event_out}, 3'h7); // pad on
		pos_mv <= 50;
		#1;
		chk(event_out, 1'b0); // no sync delay
		cyc(8);
		wr(ADDR_INT_EN, 32'h0000_0001);
		$display("test enable done");
		// each edge mode, rise then fall
		foreach (modes[i])
		begin
			m = modes[i];
			wr(ADDR_CONTROL, {26'h0, m, 4'h1});
			wr(ADDR_STATUS, 32'h0000_0001);
			pos_mv <= 200;
			cyc(8);
			wr(ADDR_STATUS, 32'h0000_0000);
			f = (m == EDGE_ANY) || (m == EDGE_RISING);
			chk(irq, f); // request follows flag
			rd_chk(ADDR_STATUS, {27'h0, 1'b1, 3'h0, f});
			wr(ADDR_STATUS, 32'h0000_0001);
			pos_mv <= 50;
			cyc(8);
			f = (m == EDGE_ANY) || (m == EDGE_FALLING);
			rd_chk(ADDR_STATUS, {31'h0, f}); // falling
		end
		$display("test edges done");
		// request masked, held, then cleared
		wr(ADDR_CONTROL, 32'h0000_0031);
		pos_mv <= 200;
		cyc(8);
		wr(ADDR_INT_EN, 32'h0000_0000);
		cyc(2);
		chk(irq, 1'b0); // masked
		wr(ADDR_INT_EN, 32'h0000_0001);
		cyc(2);
		chk(irq, 1'b1); // held while flagged
		wr(ADDR_STATUS, 32'h0000_0001);
		cyc(2);
		chk(irq, 1'b0); // cleared
		wr(ADDR_CONTROL, 32'h0000_0021);
		wr(ADDR_MUX, 32'h0000_0080);
		pos_mv <= 50;
		cyc(6);
		chk(event_out, 1'b1); // inverted event
		rd_chk(ADDR_STATUS, 32'h0000_0011); // state, invert edge
		wr(ADDR_MUX, 32'h0000_0000);
		$display("test irq and invert done");
		// sleep modes
		wr(ADDR_CONTROL, 32'h0000_0041);
		pos_mv <= 200;
		cyc(6);
		wr(ADDR_STATUS, 32'h0000_0001);
		sleep_idle <= 1'b1;
		cyc(2);
		chk({pad_drive, pad_out, event_out}, 3'h7); // idle unchanged
		sleep_idle <= 1'b0;
		sleep_standby <= 1'b1;
		cyc(2);
		chk({pad_drive, event_out}, 2'h0); // halted in standby
		wr(ADDR_CONTROL, 32'h0000_00C1);
		cyc(2);
		chk(event_out, 1'b1); // keeps running
		pos_mv <= 50;
		#1;
		chk(event_out, 1'b0); // events still update
		cyc(6);
		rd_chk(ADDR_STATUS, 32'h0000_0010); // status frozen
		sleep_standby <= 1'b0;
		cyc(6);
		rd_chk(ADDR_STATUS, 32'h0000_0001); // edge on wake
		sleep_powerdown <= 1'b1;
		pos_mv <= 200;
		cyc(2);
		chk({pad_drive, event_out, result_valid}, 3'h0);
		sleep_powerdown <= 1'b0;
		$display("test sleep done");
		// start-up hold-off, core alone then with reference
		wr(ADDR_CONTROL, 32'h0000_0000);
		wr(ADDR_CONTROL, 32'h0000_0001);
		cyc(STARTUP_CORE_CYC - 5);
		chk(result_valid, 1'b0); // core start-up
		cyc(8);
		chk(result_valid, 1'b1); // core ready
		wr(ADDR_CONTROL, 32'h0000_0000);
		wr(ADDR_MUX, {30'h0, NEG_VREF});
		wr(ADDR_CONTROL, 32'h0000_0001);
		chk(core_cfg.negative_sel, NEG_VREF); // reference routed
		cyc(STARTUP_VREF_CYC - 10);
		chk(result_valid, 1'b0); // reference start-up
		cyc(13);
		chk(result_valid, 1'b1); // reference ready
		$display("test start-up done");
		results();
	end
endmodule
